/* File: dv/compact_timer_modes_bench.sv */
// Self-checking bench for the compact timer: bus tasks, modes, pin load.
// Assumes clock select 001 counts once per system clock.
`timescale 1ns/10ps
module compact_timer_modes_bench;
  logic        pclk = 1'b0, presetn = 1'b0, ext_clk = 1'b0, win = 1'b0, err = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, cnt0;
  logic        pready, pslverr, timer_out, timer_out_en, match_a_flag, match_p_flag;
  logic [15:0] high_cnt;
  int          miscompares = 0, comparisons = 0, seed = 32'hea31, d;
  logic [7:0]  c1_tab [6] = '{8'hA8, 8'hA8, 8'hAC, 8'h98, 8'hA9, 8'h88};
  int          a_tab [6];
  always #10 pclk = ~pclk;
  always @(posedge pclk) ext_clk <= 1'($random(seed)); // Keeps the pin input moving
  ctm_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk), .timer_out(timer_out),
    .timer_out_en(timer_out_en), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
  ctm_pin_load load (.pclk(pclk), .pin(timer_out), .pin_en(timer_out_en), .win(win),
    .high_cnt(high_cnt));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; waits for ready with a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) miscompares++;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wait_flag(input bit p);
    int n;
    n = 0;
    while ((p ? match_p_flag : match_a_flag) !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 3000) miscompares++;
  endtask : wait_flag
  // Stop, clear flags, load compare A and control, then start
  task automatic run(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
    apb(1'b1, ctm_pkg::OFF_CTRL0, 32'h0);
    apb(1'b1, ctm_pkg::OFF_STATUS, 32'h3);
    apb(1'b1, ctm_pkg::OFF_CMPA_LO, {24'h0, a[7:0]});
    apb(1'b1, ctm_pkg::OFF_CMPA_HI, {30'h0, a[9:8]});
    apb(1'b1, ctm_pkg::OFF_CTRL1, {24'h0, c1});
    apb(1'b1, ctm_pkg::OFF_CTRL0, {24'h0, c0});
  endtask : run
  // High cycles in 256 clocks at a 128-clock period
  function automatic logic [31:0] exp_high(input logic [7:0] c1, input int a);
    int h;
    h = (a >= 128) ? 256 : 2 * a;
    if (c1[5:4] == ctm_pkg::IO_PWM_INACT) h = 0;
    if (c1[5:4] == ctm_pkg::IO_PWM_ACT) h = 256;
    if (c1[3] == c1[2]) h = 256 - h; // Active level is low
    return 32'(h);
  endfunction : exp_high
  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ctm_pkg::OFF_CTRL1, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b0);
    apb(1'b0, 8'h1C, 32'h0); // Unmapped word answers with an error
    check(err, 1'b1);
    for (int io = 1; io < 4; io++) begin
      d = 20 + ($unsigned($random(seed)) % 100);
      run({2'b00, 2'(io), (io == 1), 3'b000}, 10'(d), 8'h19);
      wait_flag(1'b0);
      repeat (2) @(posedge pclk);
      #1 check(timer_out, io != 1);
      wait_flag(1'b1);
      apb(1'b0, ctm_pkg::OFF_CNT_LO, 32'h0);
      check(rd < d, 1'b1);
      check({match_p_flag, match_a_flag, timer_out_en, timer_out}, {3'b111, io != 1});
    end
    run(8'h01, 10'(d), 8'h19);
    repeat (400) @(posedge pclk);
    apb(1'b0, ctm_pkg::OFF_CNT_LO, 32'h0);
    check({rd <= d, match_p_flag, match_a_flag}, 3'b101);
    run(8'h01, 10'h000, 8'h19);
    repeat (600) @(posedge pclk);
    apb(1'b0, ctm_pkg::OFF_CNT_HI, 32'h0);
    check({rd[1:0] != 2'b00, match_a_flag}, 2'b10);
    apb(1'b1, ctm_pkg::OFF_CTRL0, 32'h0);
    apb(1'b0, ctm_pkg::OFF_CNT_LO, 32'h0);
    cnt0 = rd;
    repeat (20) @(posedge pclk);
    apb(1'b0, ctm_pkg::OFF_CNT_LO, 32'h0);
    check(rd, cnt0);
    apb(1'b1, ctm_pkg::OFF_CTRL0, 32'h19);
    apb(1'b0, ctm_pkg::OFF_CNT_LO, 32'h0);
    check(rd < 8, 1'b1);
    run(8'hC0, 10'(d), 8'h19);
    wait_flag(1'b0);
    check(timer_out_en, 1'b0);
    a_tab = '{d, 200, d, d, d, d};
    for (int i = 0; i < 6; i++) begin
      run(c1_tab[i], 10'(a_tab[i]), 8'h19);
      repeat (300) @(posedge pclk);
      win <= 1'b1;
      repeat (256) @(posedge pclk);
      win <= 1'b0;
      #1 check(high_cnt, exp_high(c1_tab[i], a_tab[i]));
    end
    check({match_p_flag, match_a_flag}, 2'b11);
    run(8'hAA, 10'h100, 8'h19);
    repeat (600) @(posedge pclk);
    win <= 1'b1;
    repeat (256) @(posedge pclk);
    win <= 1'b0;
    #1 check(high_cnt inside {[127:129]}, 1'b1);
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
endmodule : compact_timer_modes_bench

/* File: dv/ctm_pin_load.sv */
// Load on the timer output pin: counts cycles the wire is high in a window.
// Assumes a pull-down on the wire, so a released pin reads low.
`timescale 1ns/10ps
module ctm_pin_load (
  // Clock
  input wire logic        pclk,
  // Pin and window
  input wire logic        pin,
  input wire logic        pin_en,
  input wire logic        win,
  // Result
  output logic     [15:0] high_cnt
);
  logic level; // Wire level seen by the load
  assign level = pin_en & pin;
  // Count high samples; a low window restarts the count
  always_ff @(posedge pclk) begin
    if (!win) high_cnt <= 16'h0000;
    else if (level) high_cnt <= high_cnt + 16'h0001;
  end
endmodule : ctm_pin_load

/* File: dv/ctm_timer_checker.sv */
// Checker for the compact timer: pin levels, match flags, bus answer.
// Bound into ctm_timer; sees only its ports and shadows control writes.
`timescale 1ns/10ps
module ctm_timer_checker (
  // Clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Timer outputs
  input wire logic        timer_out,
  input wire logic        timer_out_en,
  input wire logic        match_a_flag,
  input wire logic        match_p_flag
);
  logic [7:0] c0_ff, c1_ff; // Shadow control bytes
  logic [2:0] qt_ff;        // Cycles since last write, saturating
  logic       wr, ok, act;  // Write taken, settled, active pin level
  logic [1:0] md, io;       // Mode and output function
  assign wr = psel && penable && pready && pwrite;
  assign ok = (qt_ff == 3'h7);
  assign md = c1_ff[7:6];
  assign io = c1_ff[5:4];
  assign act = c1_ff[3] ^ c1_ff[2];
  // Shadow writes; waiting to settle hides any one-cycle output lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_ff <= 8'h00;
      c1_ff <= 8'h00;
      qt_ff <= 3'h0;
    end else begin
      if (wr && paddr == ctm_pkg::OFF_CTRL0) c0_ff <= pwdata[7:0];
      if (wr && paddr == ctm_pkg::OFF_CTRL1) c1_ff <= pwdata[7:0];
      qt_ff <= wr ? 3'h0 : (ok ? qt_ff : qt_ff + 3'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_bounded: assert property (psel && penable |-> ##[0:3] pready)
    else $error("bus answer missing");
  a_tmr_pin_free: assert property (ok && md == 2'h3 |-> !timer_out_en)
    else $error("pin driven in timer mode");
  a_cmp_pin_hold: assert property (ok && md == 2'h0 && io == 2'h0 |=> $stable(timer_out))
    else $error("pin moved with no output function");
  a_pwm_inact: assert property (ok && md == 2'h2 && io == 2'h0 |-> timer_out == !act)
    else $error("forced inactive level wrong");
  a_pwm_act: assert property (ok && md == 2'h2 && io == 2'h1 |-> timer_out == act)
    else $error("forced active level wrong");
  a_no_p_flag: assert property (ok && md == 2'h0 && c1_ff[0] && !match_p_flag |=> !match_p_flag)
    else $error("P flag raised with A clearing");
  a_init_level: assert property (wr && paddr == ctm_pkg::OFF_CTRL0 && pwdata[3] && !c0_ff[3] && md == 2'h0 |-> ##[1:3] timer_out == act)
    else $error("initial pin level not loaded");
  a_flag_clear: assert property (wr && paddr == ctm_pkg::OFF_STATUS && pwdata[0] && !c0_ff[3] |=> !match_a_flag)
    else $error("A flag not cleared");
  cover property (ok && md == 2'h2 && io == 2'h2 && timer_out);
  cover property (md == 2'h0 && match_p_flag);
  cover property (md == 2'h3 && match_a_flag);
endmodule : ctm_timer_checker
bind ctm_timer ctm_timer_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .timer_out(timer_out), .timer_out_en(timer_out_en), .match_a_flag(match_a_flag),
  .match_p_flag(match_p_flag));

/* File: src/ctm_apb_regs.sv */
// APB slave holding the timer's software registers.
// Assumes a standard APB master; answers with no wait state.
`timescale 1ns/10ps
module ctm_apb_regs (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Register contents
  output logic [7:0]       ctrl0_ff,
  output logic [7:0]       ctrl1_ff,
  output logic [9:0]       cmpa_ff,
  // Block state
  input  wire logic [9:0]  cnt,
  input  wire logic        set_af,
  input  wire logic        set_pf,
  output logic [1:0]       flags_ff
);

  logic wr_en;                                    // Write takes effect
  logic rd_en;                                    // Read is answered
  logic hit;                                      // Address is mapped

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign hit = (paddr == ctm_pkg::OFF_CTRL0) || (paddr == ctm_pkg::OFF_CTRL1) ||
               (paddr == ctm_pkg::OFF_CNT_LO) || (paddr == ctm_pkg::OFF_CNT_HI) ||
               (paddr == ctm_pkg::OFF_CMPA_LO) || (paddr == ctm_pkg::OFF_CMPA_HI) ||
               (paddr == ctm_pkg::OFF_STATUS);

  // Control and compare A writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_ff <= ctm_pkg::RST_BYTE;
      ctrl1_ff <= ctm_pkg::RST_BYTE;
      cmpa_ff <= '0;
    end else if (clk_en && wr_en) begin
      case (paddr)
        ctm_pkg::OFF_CTRL0:   ctrl0_ff <= pwdata[7:0];
        ctm_pkg::OFF_CTRL1:   ctrl1_ff <= pwdata[7:0];
        ctm_pkg::OFF_CMPA_LO: cmpa_ff[7:0] <= pwdata[7:0];
        ctm_pkg::OFF_CMPA_HI: cmpa_ff[9:8] <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Sticky flags: a match in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= 2'h0;
    end else if (clk_en) begin
      if (wr_en && paddr == ctm_pkg::OFF_STATUS) begin
        flags_ff <= (flags_ff & ~pwdata[1:0]) | {set_pf, set_af};
      end else begin
        flags_ff <= flags_ff | {set_pf, set_af};
      end
    end
  end

  // Read data is latched in setup so the access phase sees a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (rd_en) begin
        case (paddr)
          ctm_pkg::OFF_CTRL0:   prdata <= {24'h000000, ctrl0_ff};
          ctm_pkg::OFF_CTRL1:   prdata <= {24'h000000, ctrl1_ff};
          ctm_pkg::OFF_CNT_LO:  prdata <= {24'h000000, cnt[7:0]};
          ctm_pkg::OFF_CNT_HI:  prdata <= {30'h00000000, cnt[9:8]};
          ctm_pkg::OFF_CMPA_LO: prdata <= {24'h000000, cmpa_ff[7:0]};
          ctm_pkg::OFF_CMPA_HI: prdata <= {30'h00000000, cmpa_ff[9:8]};
          ctm_pkg::OFF_STATUS:  prdata <= {30'h00000000, flags_ff};
          default:              prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : ctm_apb_regs

/* File: src/ctm_pkg.sv */
// Shared constants for the compact timer block: register map, field
// positions, reset values and enumerations.
// Assumes an APB slave with 32-bit data and one register per word.
package ctm_pkg;

  // Counter and compare widths
  localparam int unsigned CNT_W = 10;             // Counter width
  localparam int unsigned CMPP_W = 3;             // Period code width
  localparam int unsigned PSEL_W = 3;             // Timer clock select width

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;       // Enable, pause, clock select, period code
  localparam logic [7:0] OFF_CTRL1 = 8'h04;       // Mode and output control
  localparam logic [7:0] OFF_CNT_LO = 8'h08;      // Counter low byte, read only
  localparam logic [7:0] OFF_CNT_HI = 8'h0C;      // Counter high bits, read only
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;     // Compare A low byte
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;     // compare_a_high_bits
  localparam logic [7:0] OFF_STATUS = 8'h18;      // Match flags, write one to clear

  // Control register 0 fields
  localparam int unsigned C0_PAUSE = 7;           // Pause bit
  localparam int unsigned C0_CK_LSB = 4;          // Clock select low bit
  localparam int unsigned C0_ON = 3;              // timer_enable_bit
  localparam int unsigned C0_RP_LSB = 0;          // compare_p_value low bit

  // Control register 1 fields
  localparam int unsigned C1_M_LSB = 6;           // mode_sel_lo
  localparam int unsigned C1_IO_LSB = 4;          // out_func_lo
  localparam int unsigned C1_OC = 3;              // out_initial_level
  localparam int unsigned C1_POL = 2;             // out_invert
  localparam int unsigned C1_DPX = 1;             // duty_period_swap
  localparam int unsigned C1_CCLR = 0;            // clear_source_sel

  // Status fields
  localparam int unsigned ST_AF = 0;              // match_a_flag
  localparam int unsigned ST_PF = 1;              // match_p_flag

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;        // All registers clear at reset
  localparam logic [9:0] RST_CNT = 10'h000;       // Counter at reset
  localparam logic [9:0] CNT_MAX = 10'h3FF;       // Counter full scale

  // Clock prescaler divide counts, in system clocks
  localparam int unsigned DIV_SYS4 = 4;           // System clock over 4
  localparam int unsigned DIV_H16 = 16;           // High clock over 16
  localparam int unsigned DIV_H64 = 64;           // High clock over 64
  localparam int unsigned DIV_TBC = 256;          // Time base clock stand-in

  // Operating modes
  typedef enum logic [1:0] {
    MODE_CMP   = 2'h0,
    MODE_UNDEF = 2'h1,
    MODE_PWM   = 2'h2,
    MODE_TMR   = 2'h3
  } ctm_mode_t;

  // Output functions in compare mode
  localparam logic [1:0] IO_CMP_NONE = 2'h0;      // No change
  localparam logic [1:0] IO_CMP_LOW = 2'h1;       // Drive low
  localparam logic [1:0] IO_CMP_HIGH = 2'h2;      // Drive high
  localparam logic [1:0] IO_CMP_TOG = 2'h3;       // Toggle

  // Output functions in PWM mode
  localparam logic [1:0] IO_PWM_INACT = 2'h0;     // Force inactive
  localparam logic [1:0] IO_PWM_ACT = 2'h1;       // Force active
  localparam logic [1:0] IO_PWM_WAVE = 2'h2;      // Waveform

endpackage : ctm_pkg

/* File: src/ctm_prescaler.sv */
// Timer clock enable generator: picks one of several system-clock
// divisions and issues a one-cycle tick at that rate.
// Assumes the external timer clock input is already synchronous.
`timescale 1ns/10ps
module ctm_prescaler #(
  parameter int unsigned DIV_W = 8                // Divider width
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // Selection
  input  wire logic [2:0]        clk_sel,
  input  wire logic              ext_clk,
  // Tick out
  output logic                   tick
);

  logic [DIV_W-1:0] div_ff;                       // Free running divider
  logic             ext_ff;                       // Previous external level
  logic             nxt_tick;                     // Combinational tick

  // Divider runs freely so every division shares one counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
      ext_ff <= 1'b0;
    end else if (clk_en) begin
      div_ff <= div_ff + 1'b1;
      ext_ff <= ext_clk;
    end
  end

  // Tick selection; the last two codes use external edges
  always_comb begin
    case (clk_sel)
      3'h0:    nxt_tick = (div_ff[1:0] == 2'h3);
      3'h1:    nxt_tick = 1'b1;
      3'h2:    nxt_tick = (div_ff[3:0] == 4'hF);
      3'h3:    nxt_tick = (div_ff[5:0] == 6'h3F);
      3'h4,
      3'h5:    nxt_tick = (div_ff == {DIV_W{1'b1}});
      3'h6:    nxt_tick = ext_clk & ~ext_ff;
      3'h7:    nxt_tick = ~ext_clk & ext_ff;
      default: nxt_tick = 1'b0;
    endcase
  end

  // Registered tick keeps the output glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= nxt_tick;
    end
  end

endmodule : ctm_prescaler

/* File: src/ctm_timer.sv */
// Compact 10-bit timer: compare, timer/counter and edge-aligned PWM.
// Assumes pclk is the system clock and all inputs are synchronous.
`timescale 1ns/10ps
module ctm_timer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer pins
  input  wire logic        ext_clk,
  output logic             timer_out,
  output logic             timer_out_en,
  // Match flags
  output logic             match_a_flag,
  output logic             match_p_flag
);

  logic [7:0]  ctrl0;                             // Enable, pause, clock, period code
  logic [7:0]  ctrl1;                             // Mode and output control
  logic [9:0]  compare_a_value;                   // Compare A register
  logic [1:0]  flags;                             // Sticky flags
  logic [31:0] prdata_w;                          // Read data from slave
  logic        pready_w;                          // Ready from slave
  logic        pslverr_w;                         // Error from slave
  logic        tick;                              // Timer clock enable
  logic [9:0]  cnt_ff;                            // Counter
  logic        on_d_ff;                           // Previous enable bit
  logic        pin_ff;                            // Compare mode pin level
  logic        set_af;                            // A flag event
  logic        set_pf;                            // P flag event
  logic        timer_enable_bit;                  // Counter on
  logic        paused;                            // Counter paused
  logic [2:0]  compare_p_value;                   // Period code
  ctm_pkg::ctm_mode_t mode; // Operating mode
  logic [1:0]  out_func; // Output function
  logic        out_initial_level; // Initial or active level
  logic        out_invert; // Pin polarity
  logic        duty_period_swap; // Period and duty swap
  logic        clear_source_sel; // Counter clear source
  logic [2:0]  clk_sel; // Timer clock choice
  logic        on_rise; // Enable went high
  logic        run_en; // Counter steps now
  logic [10:0] nxt_cnt; // Count plus one, carry kept
  logic        hit_a; // Comparator A match
  logic        hit_p; // Comparator P match
  logic        clr_cnt; // Counter clears now
  logic [10:0] duty; // Active span in ticks
  logic        pwm_act; // Wave in active phase
  logic        nxt_out; // Next pin level
  logic        nxt_out_en; // Next pin enable
  logic        timer_out_ff; // Registered pin level
  logic        timer_out_en_ff; // Registered pin enable

  // Ticks in the span of a period code; code zero spans all 1024.
  // The code sits over the top three counter bits, so spans step by 128.
  function automatic logic [10:0] code_len(input logic [2:0] code);
    return {(code == 3'h0), code, 7'h00};
  endfunction : code_len

  // Pin level for an active or inactive phase, after the invert bit
  function automatic logic drive_level(input logic act, input logic hi, input logic inv);
    return (act ? hi : ~hi) ^ inv;
  endfunction : drive_level

  // Software registers, match flags and the bus answer
  ctm_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata_w),
    .pready(pready_w),
    .pslverr(pslverr_w),
    .ctrl0_ff(ctrl0),
    .ctrl1_ff(ctrl1),
    .cmpa_ff(compare_a_value),
    .cnt(cnt_ff),
    .set_af(set_af),
    .set_pf(set_pf),
    .flags_ff(flags)
  );

  // Timer clock enable; the divider is wide enough for the slowest rate
  ctm_prescaler #(
    .DIV_W($clog2(ctm_pkg::DIV_TBC))
  ) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .clk_sel(clk_sel),
    .ext_clk(ext_clk),
    .tick(tick)
  );

  // Control fields
  assign timer_enable_bit = ctrl0[ctm_pkg::C0_ON];
  assign paused = ctrl0[ctm_pkg::C0_PAUSE];
  assign clk_sel = ctrl0[ctm_pkg::C0_CK_LSB +: ctm_pkg::PSEL_W];
  assign compare_p_value = ctrl0[ctm_pkg::C0_RP_LSB +: ctm_pkg::CMPP_W];
  assign mode = ctm_pkg::ctm_mode_t'(ctrl1[ctm_pkg::C1_M_LSB +: 2]);
  assign out_func = ctrl1[ctm_pkg::C1_IO_LSB +: 2];
  assign out_initial_level = ctrl1[ctm_pkg::C1_OC];
  assign out_invert = ctrl1[ctm_pkg::C1_POL];
  assign duty_period_swap = ctrl1[ctm_pkg::C1_DPX];
  assign clear_source_sel = ctrl1[ctm_pkg::C1_CCLR];

  // Enable history resets low like the bit itself, so leaving reset
  // never looks like a rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_d_ff <= 1'b0;
    end else if (clk_en) begin
      on_d_ff <= timer_enable_bit;
    end
  end

  // Rising edge of the enable bit restarts the count and the pin
  assign on_rise = timer_enable_bit & ~on_d_ff;

  // The tick of the restart cycle is dropped so counting starts at zero;
  // a pause keeps the residual count
  assign run_en = timer_enable_bit & ~paused & tick & ~on_rise;

  // Matches look at the value the count is about to take, so a clear
  // gives a period of exactly the programmed length
  assign nxt_cnt = {1'b0, cnt_ff} + 11'h001;

  // An A value of zero is never reached by the next count, which is at
  // least one: the counter then wraps past 3FF and raises no A flag
  assign hit_a = run_en & (nxt_cnt == {1'b0, compare_a_value});

  // The P code only ever meets the top counter bits; code zero meets
  // the carry out of 3FF, which is the overflow
  assign hit_p = run_en & (nxt_cnt == code_len(compare_p_value));

  // Clear source and flag events for each mode
  always_comb begin
    clr_cnt = 1'b0;
    set_af = 1'b0;
    set_pf = 1'b0;
    case (mode)
      ctm_pkg::MODE_PWM: begin
        // Swap bit alone picks the comparator that ends the period
        if (duty_period_swap) begin
          clr_cnt = hit_a;
        end else begin
          clr_cnt = hit_p;
        end
        set_af = hit_a;
        set_pf = hit_p;
      end
      ctm_pkg::MODE_CMP,
      ctm_pkg::MODE_TMR: begin
        if (clear_source_sel) begin
          // A clears; P never flags, whatever the two values
          clr_cnt = hit_a;
          set_af = hit_a;
        end else begin
          // P clears, or the overflow when the code is zero
          clr_cnt = hit_p;
          set_af = hit_a;
          set_pf = hit_p;
        end
      end
      default: begin
        // Undefined code: counter runs free, no flags
        clr_cnt = 1'b0;
      end
    endcase
  end

  // Counter: restart on enable, clear on the chosen match, else step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= ctm_pkg::RST_CNT;
    end else if (clk_en) begin
      if (on_rise) begin
        cnt_ff <= ctm_pkg::RST_CNT;
      end else if (clr_cnt) begin
        cnt_ff <= ctm_pkg::RST_CNT;
      end else if (run_en) begin
        // Carry is dropped on purpose: the count wraps after 3FF
        cnt_ff <= nxt_cnt[9:0];
      end
    end
  end

  // Compare mode pin level, before the invert bit. Only an A flag event or
  // the enable restart moves it; P events never touch the pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= 1'b0;
    end else if (clk_en) begin
      if (on_rise) begin
        pin_ff <= out_initial_level;
      end else if (mode == ctm_pkg::MODE_CMP && set_af) begin
        case (out_func)
          ctm_pkg::IO_CMP_LOW: begin
            pin_ff <= 1'b0;
          end
          ctm_pkg::IO_CMP_HIGH: begin
            pin_ff <= 1'b1;
          end
          ctm_pkg::IO_CMP_TOG: begin
            pin_ff <= ~pin_ff;
          end
          default: begin
            // No change; asking for the present level is no change either
            pin_ff <= pin_ff;
          end
        endcase
      end
    end
  end

  // Active span: A value, or the P code span when the two are swapped
  assign duty = duty_period_swap ? code_len(compare_p_value)
                                 : {1'b0, compare_a_value};

  // Active while the count is below the span. A span at or above the
  // period is never left, which gives full duty.
  assign pwm_act = ({1'b0, cnt_ff} < duty);

  // Pin level and enable for each mode
  always_comb begin
    nxt_out = 1'b0;
    nxt_out_en = 1'b0;
    case (mode)
      ctm_pkg::MODE_CMP: begin
        nxt_out = pin_ff ^ out_invert;
        nxt_out_en = 1'b1;
      end
      ctm_pkg::MODE_PWM: begin
        nxt_out_en = 1'b1;
        // Forced levels only mask the pin; the counter, compare and
        // flags above keep running
        case (out_func)
          ctm_pkg::IO_PWM_ACT: begin
            nxt_out = drive_level(1'b1, out_initial_level, out_invert);
          end
          ctm_pkg::IO_PWM_WAVE: begin
            nxt_out = drive_level(pwm_act, out_initial_level, out_invert);
          end
          default: begin
            // Inactive code, and the undefined one, hold the inactive level
            nxt_out = drive_level(1'b0, out_initial_level, out_invert);
          end
        endcase
      end
      default: begin
        // Timer mode and the undefined code release the pin
        nxt_out_en = 1'b0;
      end
    endcase
  end

  // Pin outputs are registered so the pads see no decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_ff <= 1'b0;
      timer_out_en_ff <= 1'b0;
    end else if (clk_en) begin
      timer_out_ff <= nxt_out;
      timer_out_en_ff <= nxt_out_en;
    end
  end

  // Outputs, each straight from a flip-flop
  assign prdata = prdata_w;
  assign pready = pready_w;
  assign pslverr = pslverr_w;
  assign match_a_flag = flags[ctm_pkg::ST_AF];
  assign match_p_flag = flags[ctm_pkg::ST_PF];
  assign timer_out = timer_out_ff;
  assign timer_out_en = timer_out_en_ff;

endmodule : ctm_timer
